// File: common/mq_fifo_pkg.sv
package mq_fifo_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int QSEL_W = 3;
    localparam int NQ_MAX = 8;
    localparam int CFG_W = 8;
    localparam int MEM_AW = 6;
    localparam int BUF_DEPTH = 8;

    // ------------------------------------------------------------
    // Queue arrangement: code equals log2 of the queue count
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        QMODE_ONE = 2'b00,
        QMODE_TWO = 2'b01,
        QMODE_FOUR = 2'b10,
        QMODE_EIGHT = 2'b11
    } qmode_t;

    // ------------------------------------------------------------
    // Configuration register layout and reset value
    // ------------------------------------------------------------
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MODE_MSB = 1;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h03;

    // ------------------------------------------------------------
    // Port widths per port_width_select code
    // ------------------------------------------------------------
    localparam int PORT_WIDTHS [8] = '{9, 12, 16, 18, 20, 24, 32, 36};

    // Used-bit mask for one port width code
    function automatic logic [DATA_W-1:0] port_mask(input logic [2:0] sel);
        port_mask = {DATA_W{1'b1}} >> (DATA_W - PORT_WIDTHS[sel]);
    endfunction

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [QSEL_W-1:0] queue;
        logic gate;
        logic cfg;
        logic mbx;
    } wr_req_t;

    localparam int WR_REQ_W = $bits(wr_req_t);

endpackage

// File: core/multi_queue_fifo_core.sv
// Operation
// - Each queue returns words in exactly the order they were accepted.
// - Write strobe with input gate stores the write data word.
// - Read strobe with output drive enable fetches the next word out.
// - Empty flag when queue holds nothing; full flag when it cannot accept.
// - Buffer splits into 8, 4, 2 or 1 independent queues.
// - Port width 9 to 36 bits; only the used data bits differ.
// - Retransmit moves read pointer back to the marked position.
// - Mailbox word passes write port to read port outside queue order.
// - Master clear empties every queue and drops all words.
// - Input gate masks queue memory stores only, output drive enable skips reads.
// - Write strobe advances write pointer even with input gate off.
// - Master clear zeroes pointers, output, full flags; sets empty flag; selects eight queues.
// - Config select low targets config over low byte, else mailbox with mailbox select high, otherwise queue memory.
// - Queue picks choose queue per access, per configured queue count.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Request buffer: small FIFO in front of the queue memory
// ------------------------------------------------------------
module req_buffer #(
    parameter int WIDTH = mq_fifo_pkg::WR_REQ_W,
    parameter int DEPTH = mq_fifo_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slots [DEPTH];
    logic [PW-1:0] head_r;
    logic [PW-1:0] tail_r;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic ready_r;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign push = in_valid & ready_r;
    assign pop = out_valid & out_ready;
    assign out_valid = (count_r != '0);
    assign out_data = slots[head_r];
    assign in_ready = ready_r;

    // Occupancy; ready is a flop so the writer sees no combinational path
    always_comb begin
        count_nxt = count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    // Pointers and occupancy; depth must be a power of two for wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_r <= '0;
            tail_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else if (flush) begin
            head_r <= '0;
            tail_r <= '0;
            count_r <= '0;
            ready_r <= 1'b1;
        end else begin
            if (push) begin
                tail_r <= tail_r + 1'b1;
            end
            if (pop) begin
                head_r <= head_r + 1'b1;
            end
            count_r <= count_nxt;
            ready_r <= (count_nxt < (PW + 1)'(DEPTH));
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            slots[tail_r] <= in_data;
        end
    end
endmodule // req_buffer

// ------------------------------------------------------------
// Multi-queue FIFO core
// ------------------------------------------------------------
module multi_queue_fifo_core #(
    parameter int AW = mq_fifo_pkg::MEM_AW,
    parameter int BUF_DEPTH = mq_fifo_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clear,
    input wire logic [2:0] port_width_select,
    input wire logic config_access_select,
    input wire logic mailbox_select,
    input wire logic wr_en,
    input wire logic data_input_gate,
    input wire logic [mq_fifo_pkg::QSEL_W-1:0] write_queue_pick,
    input wire logic [mq_fifo_pkg::DATA_W-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_en,
    input wire logic output_drive_enable,
    input wire logic [mq_fifo_pkg::QSEL_W-1:0] read_queue_pick,
    input wire logic mark_request,
    input wire logic retransmit_request,
    output logic [mq_fifo_pkg::DATA_W-1:0] rd_data,
    output logic output_word_valid,
    output logic [mq_fifo_pkg::QSEL_W-1:0] output_queue_tag,
    output logic empty_flag,
    output logic full_flag,
    output logic mailbox_full
);
    localparam int NQ = mq_fifo_pkg::NQ_MAX;
    localparam int DW = mq_fifo_pkg::DATA_W;
    localparam int QW = mq_fifo_pkg::QSEL_W;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Offset mask inside one queue's region
    function automatic logic [AW-1:0] region_mask(input mq_fifo_pkg::qmode_t m);
        region_mask = {AW{1'b1}} >> m;
    endfunction

    // Queue index from a pick, per queue count
    function automatic logic [QW-1:0] pick_queue(input logic [QW-1:0] pick, input mq_fifo_pkg::qmode_t m);
        pick_queue = pick & ({QW{1'b1}} >> (QW - int'(m)));
    endfunction

    // Memory address of an offset in a queue's region
    function automatic logic [AW-1:0] mem_addr(input logic [QW-1:0] q, input mq_fifo_pkg::qmode_t m,
                                               input logic [AW-1:0] off);
        logic [AW-1:0] b;
        b = '0;
        b[QW-1:0] = q;
        mem_addr = (b << (AW - int'(m))) | off;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DW-1:0] mem [1 << AW];
    logic [AW-1:0] wptr_r [NQ];
    logic [AW-1:0] rptr_r [NQ];
    logic [AW-1:0] mark_r [NQ];
    logic [AW:0] cnt_r [NQ];
    logic [mq_fifo_pkg::CFG_W-1:0] cfg_r;
    logic [DW-1:0] mailbox_r;
    logic mbx_full_r;
    mq_fifo_pkg::qmode_t mode;

    // Request buffer signals
    mq_fifo_pkg::wr_req_t req_in;
    mq_fifo_pkg::wr_req_t req;
    logic [mq_fifo_pkg::WR_REQ_W-1:0] req_bits;
    logic req_valid;
    logic req_ready;

    // Decoded accesses
    logic [AW-1:0] rmask;
    logic [AW:0] region;
    logic [QW-1:0] wq;
    logic [QW-1:0] rq;
    logic wq_room;
    logic rq_has;
    logic do_wr;
    logic do_cfg_wr;
    logic do_mbx_wr;
    logic rd_cfg;
    logic rd_mbx;
    logic rd_q;

    assign mode = mq_fifo_pkg::qmode_t'(cfg_r[mq_fifo_pkg::CFG_MODE_MSB:mq_fifo_pkg::CFG_MODE_LSB]);
    assign rmask = region_mask(mode);
    assign region = {1'b0, rmask} + 1'b1;

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------

    // Unused high bits are zeroed so narrow ports behave alike
    assign req_in.data = wr_data & mq_fifo_pkg::port_mask(port_width_select);
    assign req_in.queue = write_queue_pick;
    assign req_in.gate = data_input_gate;
    assign req_in.cfg = ~config_access_select;
    assign req_in.mbx = mailbox_select;

    req_buffer #(
        .WIDTH(mq_fifo_pkg::WR_REQ_W),
        .DEPTH(BUF_DEPTH)
    ) u_req_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .flush(master_clear),
        .in_valid(wr_en & ~master_clear),
        .in_ready(wr_ready),
        .in_data(req_in),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data(req_bits)
    );

    assign req = mq_fifo_pkg::wr_req_t'(req_bits);
    assign wq = pick_queue(req.queue, mode);
    assign wq_room = (cnt_r[wq] != region);

    // A full queue stalls the buffer instead of overwriting
    assign req_ready = ~master_clear & (req.cfg | req.mbx | wq_room);
    assign do_cfg_wr = req_valid & req_ready & req.cfg;
    assign do_mbx_wr = req_valid & req_ready & ~req.cfg & req.mbx;
    assign do_wr = req_valid & req_ready & ~req.cfg & ~req.mbx;

    // ------------------------------------------------------------
    // Read side decode
    // ------------------------------------------------------------
    assign rq = pick_queue(read_queue_pick, mode);
    assign rq_has = (cnt_r[rq] != '0);
    assign rd_cfg = rd_en & ~config_access_select & ~master_clear;
    assign rd_mbx = rd_en & config_access_select & mailbox_select & ~master_clear;
    assign rd_q = rd_en & config_access_select & ~mailbox_select & rq_has & ~master_clear;

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------

    // Low byte only; master clear restores eight queues
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= mq_fifo_pkg::CFG_RESET;
        end else if (master_clear) begin
            cfg_r <= mq_fifo_pkg::CFG_RESET;
        end else if (do_cfg_wr) begin
            cfg_r <= req.data[mq_fifo_pkg::CFG_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Queue pointers and counts
    // ------------------------------------------------------------

    // Regions change with the queue count, so a config write restarts all queues
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NQ; i++) begin
                wptr_r[i] <= '0;
                rptr_r[i] <= '0;
                mark_r[i] <= '0;
                cnt_r[i] <= '0;
            end
        end else if (master_clear || do_cfg_wr) begin
            for (int i = 0; i < NQ; i++) begin
                wptr_r[i] <= '0;
                rptr_r[i] <= '0;
                mark_r[i] <= '0;
                cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NQ; i++) begin
                logic w;
                logic r;
                logic rt;
                logic [AW:0] base_cnt;
                w = do_wr && (wq == QW'(i));
                r = rd_q && (rq == QW'(i)) && !retransmit_request;
                rt = retransmit_request && rd_en == 1'b0 && (rq == QW'(i));
                base_cnt = cnt_r[i];
                // Pointer advances even when the gate masks the store
                if (w) begin
                    wptr_r[i] <= (wptr_r[i] + 1'b1) & rmask;
                end
                // Skipped reads still consume the word
                if (r) begin
                    rptr_r[i] <= (rptr_r[i] + 1'b1) & rmask;
                end
                if (mark_request && (rq == QW'(i))) begin
                    mark_r[i] <= rptr_r[i];
                end
                // Words between mark and read pointer come back into the count
                if (rt) begin
                    rptr_r[i] <= mark_r[i];
                    base_cnt = cnt_r[i] + {1'b0, (rptr_r[i] - mark_r[i]) & rmask};
                end
                cnt_r[i] <= base_cnt + {{AW{1'b0}}, w} - {{AW{1'b0}}, r};
            end
        end
    end

    // ------------------------------------------------------------
    // Memory store
    // ------------------------------------------------------------

    // Gate low leaves the location untouched
    always_ff @(posedge clk) begin
        if (do_wr && req.gate) begin
            mem[mem_addr(wq, mode, wptr_r[wq])] <= req.data;
        end
    end

    // ------------------------------------------------------------
    // Mailbox
    // ------------------------------------------------------------

    // Bypasses queue order; a new word in the read cycle keeps it full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mailbox_r <= '0;
            mbx_full_r <= 1'b0;
        end else if (master_clear) begin
            mailbox_r <= '0;
            mbx_full_r <= 1'b0;
        end else if (do_mbx_wr) begin
            mailbox_r <= req.data;
            mbx_full_r <= 1'b1;
        end else if (rd_mbx && output_drive_enable) begin
            mbx_full_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Word presented only with the output drive enable on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
            output_word_valid <= 1'b0;
            output_queue_tag <= '0;
        end else if (master_clear) begin
            rd_data <= '0;
            output_word_valid <= 1'b0;
            output_queue_tag <= '0;
        end else begin
            output_word_valid <= 1'b0;
            if (output_drive_enable) begin
                if (rd_cfg) begin
                    rd_data <= DW'(cfg_r);
                    output_word_valid <= 1'b1;
                end else if (rd_mbx && mbx_full_r) begin
                    rd_data <= mailbox_r & mq_fifo_pkg::port_mask(port_width_select);
                    output_word_valid <= 1'b1;
                end else if (rd_q && !retransmit_request) begin
                    rd_data <= mem[mem_addr(rq, mode, rptr_r[rq])] &
                               mq_fifo_pkg::port_mask(port_width_select);
                    output_word_valid <= 1'b1;
                    output_queue_tag <= rq;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------

    // Registered, so they trail the counts by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            empty_flag <= 1'b1;
            full_flag <= 1'b0;
            mailbox_full <= 1'b0;
        end else if (master_clear) begin
            empty_flag <= 1'b1;
            full_flag <= 1'b0;
            mailbox_full <= 1'b0;
        end else begin
            empty_flag <= ~rq_has;
            full_flag <= (cnt_r[pick_queue(write_queue_pick, mode)] == region);
            mailbox_full <= mbx_full_r;
        end
    end
endmodule // multi_queue_fifo_core

// File: sim/mq_fifo_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checks of the multi-queue FIFO core
// ------------------------------------------------------------
module mq_fifo_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clear,
    input wire logic [2:0] port_width_select,
    input wire logic config_access_select,
    input wire logic mailbox_select,
    input wire logic wr_en,
    input wire logic wr_ready,
    input wire logic rd_en,
    input wire logic output_drive_enable,
    input wire logic [mq_fifo_pkg::QSEL_W-1:0] read_queue_pick,
    input wire logic [mq_fifo_pkg::DATA_W-1:0] rd_data,
    input wire logic output_word_valid,
    input wire logic [mq_fifo_pkg::QSEL_W-1:0] output_queue_tag,
    input wire logic empty_flag,
    input wire logic full_flag,
    input wire logic mailbox_full
);
    // One clock domain only
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    clear_state_a: assert property (master_clear |=> !output_word_valid && rd_data == '0 && !full_flag
        && !mailbox_full && wr_ready) else $error("state not cleared");
    clear_empty_a: assert property (master_clear [*2] |=> empty_flag) else $error("queue not empty after clear");
    valid_cause_a: assert property (output_word_valid |-> $past(rd_en) && $past(output_drive_enable))
        else $error("word shown without read");
    skip_silent_a: assert property (rd_en && !output_drive_enable |=> !output_word_valid)
        else $error("skipped read shown");
    mbx_set_a: assert property (wr_en && wr_ready && config_access_select && mailbox_select && !master_clear
        |-> ##[1:3] mailbox_full) else $error("mailbox not set");
    mbx_read_a: assert property (rd_en && output_drive_enable && config_access_select && mailbox_select
        && mailbox_full && !wr_en && !master_clear |=> output_word_valid ##[0:2] !mailbox_full)
        else $error("mailbox read wrong");
    width_mask_a: assert property (output_word_valid
        |-> (rd_data >> mq_fifo_pkg::PORT_WIDTHS[$past(port_width_select)]) == '0) else $error("unused bits set");
    tag_match_a: assert property (output_word_valid && $past(config_access_select) && !$past(mailbox_select)
        |-> output_queue_tag == $past(read_queue_pick)) else $error("queue tag wrong");
endmodule // mq_fifo_properties

// File: sim/multi_queue_fifo_core_tb.sv
`timescale 1ns/1ps
module multi_queue_fifo_core_tb;
    logic clk, rst_n, master_clear, config_access_select, mailbox_select, wr_en, data_input_gate;
    logic rd_en, output_drive_enable, mark_request, retransmit_request, wr_ready, output_word_valid;
    logic empty_flag, full_flag, mailbox_full;
    logic [2:0] port_width_select;
    logic [mq_fifo_pkg::QSEL_W-1:0] write_queue_pick, read_queue_pick, output_queue_tag;
    logic [mq_fifo_pkg::DATA_W-1:0] wr_data, rd_data;
    int errors, cmp_count, presented, cyc, seen;

    multi_queue_fifo_core multi_queue_fifo_core_i (.clk(clk), .rst_n(rst_n), .master_clear(master_clear),
        .port_width_select(port_width_select), .config_access_select(config_access_select),
        .mailbox_select(mailbox_select), .wr_en(wr_en), .data_input_gate(data_input_gate),
        .write_queue_pick(write_queue_pick), .wr_data(wr_data), .wr_ready(wr_ready), .rd_en(rd_en),
        .output_drive_enable(output_drive_enable), .read_queue_pick(read_queue_pick),
        .mark_request(mark_request), .retransmit_request(retransmit_request), .rd_data(rd_data),
        .output_word_valid(output_word_valid), .output_queue_tag(output_queue_tag),
        .empty_flag(empty_flag), .full_flag(full_flag), .mailbox_full(mailbox_full));
    word_sink word_sink_i (.clk(clk), .rst_n(rst_n), .output_word_valid(output_word_valid), .seen(seen));

    // ------------------------------------------------------------
    // Clock, hang guard, shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Whole run needs about 500 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_data({35'h0, got}, {35'h0, exp});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One write, held until the request buffer takes it
    task automatic wr(input logic [2:0] q, input logic [35:0] d, input logic g, input logic sel, input logic mb);
        config_access_select = sel;
        mailbox_select = mb;
        write_queue_pick = q;
        wr_data = d;
        data_input_gate = g;
        wr_en = 1'b1;
        // A stuck buffer is caught by the cycle ceiling, never passed over
        while (wr_ready !== 1'b1) begin
            step(1);
        end
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask

    // One read; the presented word stands only in the cycle after the edge
    task automatic rd(input logic [2:0] q, input logic oe, input logic sel, input logic mb, input logic ev,
                      input logic [35:0] exp, input logic dc);
        config_access_select = sel;
        mailbox_select = mb;
        read_queue_pick = q;
        output_drive_enable = oe;
        rd_en = 1'b1;
        step(1);
        rd_en = 1'b0;
        chk_bit(output_word_valid, ev);
        if (dc) chk_data(rd_data, exp);
        if (ev) presented++;
        step(1);
    endtask

    // Flags lag the counts, so let them settle first
    task automatic flags(input logic [2:0] q, input logic e, input logic f);
        read_queue_pick = q;
        write_queue_pick = q;
        step(3);
        chk_bit(empty_flag, e);
        chk_bit(full_flag, f);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, master_clear, config_access_select, mailbox_select, wr_en, data_input_gate} = '0;
        {rd_en, output_drive_enable, mark_request, retransmit_request} = '0;
        {write_queue_pick, read_queue_pick, wr_data} = '0;
        port_width_select = 3'h7;
        config_access_select = 1'b1;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        step(2);
        chk_data(rd_data, 36'h0_0000_0000);
        flags(3'h0, 1'b1, 1'b0);
        done("reset");
        for (int m = 0; m < 4; m++) begin
            wr(3'h0, 36'(m), 1'b1, 1'b0, 1'b0);
            rd(3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 36'(m), 1'b1);
            wr(3'((1 << m) - 1), 36'h0_00A0_0000 + 36'(m), 1'b1, 1'b1, 1'b0);
            step(3);
            rd(3'((1 << m) - 1), 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_00A0_0000 + 36'(m), 1'b1);
        end
        done("modes");
        for (int i = 0; i < 3; i++) wr(3'h0, 36'h0_0000_0100 + 36'(i), 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 2; i++) wr(3'h5, 36'h0_0000_0200 + 36'(i), 1'b1, 1'b1, 1'b0);
        step(3);
        for (int i = 0; i < 2; i++) rd(3'h5, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0200 + 36'(i), 1'b1);
        chk_data(36'(output_queue_tag), 36'h0_0000_0005);
        for (int i = 0; i < 3; i++) rd(3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0100 + 36'(i), 1'b1);
        done("order");
        wr(3'h1, 36'h0_0000_0301, 1'b0, 1'b1, 1'b0);
        wr(3'h1, 36'h0_0000_0302, 1'b1, 1'b1, 1'b0);
        wr(3'h2, 36'h0_0000_0401, 1'b1, 1'b1, 1'b0);
        wr(3'h2, 36'h0_0000_0402, 1'b1, 1'b1, 1'b0);
        step(3);
        rd(3'h1, 1'b1, 1'b1, 1'b0, 1'b1, '0, 1'b0);
        rd(3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0302, 1'b1);
        rd(3'h2, 1'b0, 1'b1, 1'b0, 1'b0, '0, 1'b0);
        rd(3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0402, 1'b1);
        flags(3'h2, 1'b1, 1'b0);
        rd(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, '0, 1'b0);
        wr(3'h2, 36'h0_0000_0403, 1'b1, 1'b1, 1'b0);
        step(3);
        rd(3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0403, 1'b1);
        done("mask skip");
        wr(3'h0, 36'h0_0000_5555, 1'b1, 1'b1, 1'b1);
        step(3);
        chk_bit(mailbox_full, 1'b1);
        rd(3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 36'h0_0000_5555, 1'b1);
        flags(3'h0, 1'b1, 1'b0);
        done("mailbox");
        for (int i = 0; i < 3; i++) wr(3'h3, 36'h0_0000_0600 + 36'(i), 1'b1, 1'b1, 1'b0);
        read_queue_pick = 3'h3;
        step(3);
        mark_request = 1'b1;
        step(1);
        mark_request = 1'b0;
        step(1);
        for (int i = 0; i < 2; i++) rd(3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0600 + 36'(i), 1'b1);
        retransmit_request = 1'b1;
        step(1);
        retransmit_request = 1'b0;
        step(2);
        for (int i = 0; i < 3; i++) rd(3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_0600 + 36'(i), 1'b1);
        done("retransmit");
        // Every width code, expected mask built from the width table
        for (int w = 0; w < 8; w++) begin
            port_width_select = 3'(w);
            wr(3'h4, 36'hF_FFFF_FFFF, 1'b1, 1'b1, 1'b0);
            step(3);
            rd(3'h4, 1'b1, 1'b1, 1'b0, 1'b1, 36'((37'h1 << mq_fifo_pkg::PORT_WIDTHS[w]) - 37'h1), 1'b1);
        end
        port_width_select = 3'h7;
        done("width");
        // One queue of 64 words; the 65th waits in the request buffer
        wr(3'h0, 36'h0_0000_0000, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 65; i++) wr(3'h0, 36'h0_0000_1000 + 36'(i), 1'b1, 1'b1, 1'b0);
        flags(3'h0, 1'b0, 1'b1);
        for (int i = 0; i < 65; i++) rd(3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 36'h0_0000_1000 + 36'(i), 1'b1);
        flags(3'h0, 1'b1, 1'b0);
        done("full");
        wr(3'h0, 36'h0_0000_0077, 1'b1, 1'b1, 1'b0);
        step(3);
        master_clear = 1'b1;
        step(2);
        master_clear = 1'b0;
        step(1);
        chk_data(rd_data, 36'h0_0000_0000);
        flags(3'h0, 1'b1, 1'b0);
        rd(3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 36'h0_0000_0003, 1'b1);
        rd(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, '0, 1'b0);
        done("clear");
        chk_data(36'(seen), 36'(presented));
        close_out();
    end
endmodule // multi_queue_fifo_core_tb

bind multi_queue_fifo_core mq_fifo_properties mq_fifo_properties_i (.clk(clk), .rst_n(rst_n),
    .master_clear(master_clear), .port_width_select(port_width_select),
    .config_access_select(config_access_select), .mailbox_select(mailbox_select), .wr_en(wr_en),
    .wr_ready(wr_ready), .rd_en(rd_en), .output_drive_enable(output_drive_enable),
    .read_queue_pick(read_queue_pick), .rd_data(rd_data), .output_word_valid(output_word_valid),
    .output_queue_tag(output_queue_tag), .empty_flag(empty_flag), .full_flag(full_flag),
    .mailbox_full(mailbox_full));

// File: sim/word_sink.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Reading agent: counts every word the core presents
// ------------------------------------------------------------
module word_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic output_word_valid,
    output int seen
);
    // Shares the core clock, so the rate ratio is always 1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 0;
        end else if (output_word_valid === 1'b1) begin
            seen <= seen + 1;
        end
    end
endmodule // word_sink
